// ==== io_route_pkg.sv ====
package io_route_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_INPUT_A_SELECT = 8'h00;
   localparam logic [7:0] OFF_INPUT_B_SELECT = 8'h04;
   localparam logic [7:0] OFF_SOURCE_ASSIGN = 8'h08;
   localparam logic [7:0] OFF_OUTPUT_ONE_CONFIG = 8'h0c;
   localparam logic [7:0] OFF_OPTIONS = 8'h10;
   localparam logic [7:0] OFF_GROUP_BASE = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam int NUM_GROUPS = 5;

   // Input function codes.
   localparam logic [3:0] FN_NONE = 4'h0;
   localparam logic [3:0] FN_FAULT_CLEAR = 4'h1;
   localparam logic [3:0] FN_USER_ERROR = 4'h2;
   localparam logic [3:0] FN_CHANNEL_SWITCH = 4'h3;
   localparam logic [3:0] FN_FORCE_LOCAL = 4'h4;
   localparam logic [3:0] FN_ERROR_INHIBIT = 4'h5;
   localparam logic [3:0] FN_DEVICE_LOCKOUT = 4'h6;
   localparam logic [3:0] FN_COAST_STOP = 4'h7;
   localparam logic [3:0] FN_THERMAL_CLEAR = 4'h8;
   localparam logic [3:0] FN_CASCADE_HANDOVER = 4'h9;
   localparam logic [3:0] FN_ALTERNATE_PARAMETER = 4'ha;
   localparam logic [3:0] FN_PREHEAT = 4'hb;
   localparam int FN_LAST = 11;

   // Input source codes in the source view and the assign register.
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_INPUT_A = 2'h1;
   localparam logic [1:0] SRC_INPUT_B = 2'h2;

   // Output one condition codes.
   localparam logic [3:0] COND_NONE = 4'h0;
   localparam logic [3:0] COND_FAULT_STATE = 4'h1;
   localparam logic [3:0] COND_RUNNING = 4'h2;
   localparam logic [3:0] COND_READY = 4'h3;
   localparam logic [3:0] COND_DISPLAY_CONTROL = 4'h4;
   localparam logic [3:0] COND_LINE_CONTACTOR = 4'h5;
   localparam logic [3:0] COND_GROUP_ONE = 4'h6;
   localparam logic [3:0] COND_INHIBITED_ERRORS = 4'hb;
   localparam logic [3:0] COND_SECOND_PARAMETERS = 4'hc;
   localparam logic [3:0] COND_MOTOR_OVERLOAD_WARNING = 4'hd;

   // Field positions.
   localparam int POS_ASSIGN_INPUT = 4;
   localparam int POS_OUTPUT_POLARITY = 8;
   localparam int POS_EXT_ERROR_LOW = 0;
   localparam int POS_FORCE_LOCAL_CHANNEL = 1;

   // Warning indices inside the warning vector.
   localparam int MISSING_BATTERY_IDX = 0;
   localparam int LOW_BATTERY_IDX = 1;
   localparam int INVALID_CALENDAR_IDX = 2;
   localparam int MOTOR_OVERLOAD_WARN_IDX = 3;

   // Reset values.
   localparam logic [3:0] RST_INPUT_A_SELECT = FN_COAST_STOP;
   localparam logic [3:0] RST_INPUT_B_SELECT = FN_FORCE_LOCAL;
   localparam logic [3:0] RST_OUTPUT_CONDITION = COND_MOTOR_OVERLOAD_WARNING;
   localparam logic RST_OUTPUT_NEGATIVE = 1'b0;
   localparam logic RST_EXT_ERROR_LOW = 1'b0;
   localparam logic [1:0] RST_FORCE_LOCAL_CHANNEL = 2'h0;
   localparam logic [31:0] RST_GROUP_ONE_MEMBERS = 32'h00000007;
   localparam logic [31:0] RST_OTHER_GROUP_MEMBERS = 32'h00000000;

endpackage : io_route_pkg

// ==== io_function_assignment.sv ====
// Operation
// R1: Each of five groups drives its condition when any member warning fires.
// R2: Warnings in no group are hidden from display, indicators and event log.
// R3: After reset, battery and calendar warnings already sit in group one.
// R4: Assignable inputs are active on a high level unless stated otherwise.
// R5: One function per input; a new selection drops the earlier one.
// R6: Reset defaults: input a selects coast stop, input b forced local.
// R7: Fault clear resets a latched error; its cause must be gone first.
// R8: User error raised while the input matches the configured polarity.
// R9: Channel switch: low selects channel one, high two; assign via source only.
// R10: Forced local puts control on the configured local channel.
// R11: Error inhibit records errors but keeps the device out of fault.
// R12: Device lockout is active low and forces the contactor relay open.
// R13: While coast stop is active the next stop is a freewheel stop.
// R14: Thermal clear resets the motor overload error once its cause is gone.
// R15: Cascade handover takes control and opens the external bypass.
// R16: Alternate parameter function selects the second motor parameter set.
// R17: Asserting the preheat function starts the preheating sequence.
// R18: Choosing an input function points that function's source at the input.
// R19: Output one follows one selected condition, default motor overload warning.
// R20: Output polarity: positive drives high on true, negative drives low.
// R21: Inhibited errors condition is true while the error inhibit input is active.
// R22: Display control condition is true only while display control is active.
// R23: Fault clear acts on a rising edge of its input.
// R24: Thermal clear acts on a rising edge of its input.
// R25: Each input passes two synchronising flip-flops before detection.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module io_function_assignment
#(
   parameter int NUM_WARN = 16
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic DIN_A,
   input wire logic DIN_B,
   input wire logic [NUM_WARN-1:0] WARN_IN,
   input wire logic FAULT_STATE,
   input wire logic RUNNING,
   input wire logic READY,
   input wire logic DISPLAY_CONTROL,
   input wire logic LINE_CONTACTOR,
   input wire logic ERROR_EVENT,
   input wire logic ERROR_CAUSE,
   input wire logic OVERLOAD_EVENT,
   input wire logic OVERLOAD_CAUSE,
   input wire logic STOP_REQUEST,
   output logic [NUM_WARN-1:0] WARN_VISIBLE,
   output logic [io_route_pkg::NUM_GROUPS-1:0] GROUP_ACTIVE,
   output logic ERROR_LATCHED,
   output logic ERROR_RECORD,
   output logic FAULT_TRIP,
   output logic OVERLOAD_LATCHED,
   output logic USER_ERROR,
   output logic CHANNEL_TWO,
   output logic FORCE_LOCAL,
   output logic [1:0] FORCE_LOCAL_CHANNEL,
   output logic CONTACTOR_FORCE_OPEN,
   output logic STOP_COAST,
   output logic STOP_NORMAL,
   output logic BYPASS_OPEN,
   output logic SECOND_PARAM_SET,
   output logic PREHEAT_START,
   output logic DOUT_ONE
);
   import io_route_pkg::*;

   generate
      if (NUM_WARN < MOTOR_OVERLOAD_WARN_IDX + 1 || NUM_WARN > 32)
      begin : g_bad_width
         $error("NUM_WARN must lie between 4 and 32");
      end
   endgenerate

   logic rst_meta, rst_n, din_a_meta, din_b_meta, din_a, din_b;
   logic [3:0] sel_a, sel_b, out_cond, wr_fn;
   logic out_negative, ext_error_low;
   logic [1:0] local_channel, wr_src;
   logic [NUM_WARN-1:0] members [NUM_GROUPS];
   logic [FN_LAST:0] act, act_prev, rise;
   logic [31:0] src_view, next_rdata;
   logic [NUM_GROUPS-1:0] group_hit;
   logic [NUM_WARN-1:0] any_member;
   logic error_latched, overload_latched, cond_value, setup, access, wr, mapped;

   // Reset is asserted at once but released through two flops.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else if (CE)
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         din_a_meta <= 1'b0;
         din_b_meta <= 1'b0;
         din_a <= 1'b0;
         din_b <= 1'b0;
      end
      else if (CE)
      begin
         din_a_meta <= DIN_A; // see R25
         din_b_meta <= DIN_B; // see R25
         din_a <= din_a_meta;
         din_b <= din_b_meta;
      end
   end

   genvar f;
   generate
      for (f = 0; f <= FN_LAST; f++)
      begin : g_fn
         logic on_a;
         logic on_b;
         logic level;
         logic invert;
         assign on_a = (f != 0) && (sel_a == 4'(f));
         assign on_b = (f != 0) && (sel_b == 4'(f));
         assign level = on_a ? din_a : din_b;
         // Lockout is active low; user error follows its polarity setting.
         assign invert = (4'(f) == FN_DEVICE_LOCKOUT) ||
                         ((4'(f) == FN_USER_ERROR) && ext_error_low); // see R4, R8, R12
         assign act[f] = (on_a || on_b) && (level ^ invert); // see R4
         assign rise[f] = act[f] && !act_prev[f];
         assign src_view[2*f+1:2*f] = on_a ? SRC_INPUT_A :
                                      (on_b ? SRC_INPUT_B : SRC_NONE); // see R18
      end
   endgenerate

   assign src_view[31:2*FN_LAST+2] = '0;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         act_prev <= '0;
      else if (CE)
         act_prev <= act; // see R23, R24
   end

   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++)
      begin : g_grp
         assign group_hit[g] = |(WARN_IN & members[g]); // see R1
      end
   endgenerate

   always_comb
   begin
      any_member = '0;
      for (int i = 0; i < NUM_GROUPS; i++)
      begin
         any_member = any_member | members[i];
      end
   end

   // APB decode; the slave answers with no wait states.
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign wr = access && PWRITE && mapped;
   assign PREADY = 1'b1;
   assign PSLVERR = access && !mapped;
   assign wr_fn = PWDATA[3:0];
   assign wr_src = PWDATA[POS_ASSIGN_INPUT+1:POS_ASSIGN_INPUT];

   always_comb
   begin
      mapped = 1'b1;
      next_rdata = '0;
      unique case (PADDR)
         OFF_INPUT_A_SELECT: next_rdata[3:0] = sel_a;
         OFF_INPUT_B_SELECT: next_rdata[3:0] = sel_b;
         OFF_SOURCE_ASSIGN: next_rdata = src_view;
         OFF_OUTPUT_ONE_CONFIG:
         begin
            next_rdata[3:0] = out_cond;
            next_rdata[POS_OUTPUT_POLARITY] = out_negative;
         end
         OFF_OPTIONS:
         begin
            next_rdata[POS_EXT_ERROR_LOW] = ext_error_low;
            next_rdata[POS_FORCE_LOCAL_CHANNEL+1:POS_FORCE_LOCAL_CHANNEL] = local_channel;
         end
         OFF_GROUP_BASE: next_rdata[NUM_WARN-1:0] = members[0];
         OFF_GROUP_BASE + 8'h04: next_rdata[NUM_WARN-1:0] = members[1];
         OFF_GROUP_BASE + 8'h08: next_rdata[NUM_WARN-1:0] = members[2];
         OFF_GROUP_BASE + 8'h0c: next_rdata[NUM_WARN-1:0] = members[3];
         OFF_GROUP_BASE + 8'h10: next_rdata[NUM_WARN-1:0] = members[4];
         OFF_STATUS:
         begin
            next_rdata[0] = din_a;
            next_rdata[1] = din_b;
            next_rdata[2] = error_latched;
            next_rdata[3] = overload_latched;
            next_rdata[8:4] = group_hit;
            next_rdata[9] = DOUT_ONE;
            next_rdata[31:20] = act;
         end
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         PRDATA <= '0;
      else if (CE && setup)
         PRDATA <= next_rdata;
   end

   // Channel switching is refused here; an input carrying it is freed only
   // through the source register.
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_a <= RST_INPUT_A_SELECT; // see R6
         sel_b <= RST_INPUT_B_SELECT; // see R6
      end
      else if (CE && wr)
      begin
         if (PADDR == OFF_INPUT_A_SELECT && sel_a != FN_CHANNEL_SWITCH &&
             wr_fn != FN_CHANNEL_SWITCH && wr_fn <= 4'(FN_LAST)) // see R9
         begin
            sel_a <= wr_fn; // see R5, R18
            if (sel_b == wr_fn && wr_fn != FN_NONE)
               sel_b <= FN_NONE;
         end
         else if (PADDR == OFF_INPUT_B_SELECT && sel_b != FN_CHANNEL_SWITCH &&
                  wr_fn != FN_CHANNEL_SWITCH && wr_fn <= 4'(FN_LAST)) // see R9
         begin
            sel_b <= wr_fn; // see R5, R18
            if (sel_a == wr_fn && wr_fn != FN_NONE)
               sel_a <= FN_NONE;
         end
         else if (PADDR == OFF_SOURCE_ASSIGN && wr_fn != FN_NONE &&
                  wr_fn <= 4'(FN_LAST))
         begin
            // A function has one source; assigning it moves it off the other input.
            if (sel_a == wr_fn)
               sel_a <= FN_NONE;
            if (sel_b == wr_fn)
               sel_b <= FN_NONE;
            if (wr_src == SRC_INPUT_A &&
                (sel_a != FN_CHANNEL_SWITCH || wr_fn == FN_CHANNEL_SWITCH))
               sel_a <= wr_fn; // see R5, R9
            else if (wr_src == SRC_INPUT_B &&
                     (sel_b != FN_CHANNEL_SWITCH || wr_fn == FN_CHANNEL_SWITCH))
               sel_b <= wr_fn; // see R5, R9
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_cond <= RST_OUTPUT_CONDITION; // see R19
         out_negative <= RST_OUTPUT_NEGATIVE; // see R20
         ext_error_low <= RST_EXT_ERROR_LOW;
         local_channel <= RST_FORCE_LOCAL_CHANNEL;
      end
      else if (CE && wr)
      begin
         if (PADDR == OFF_OUTPUT_ONE_CONFIG)
         begin
            out_cond <= PWDATA[3:0];
            out_negative <= PWDATA[POS_OUTPUT_POLARITY];
         end
         if (PADDR == OFF_OPTIONS)
         begin
            ext_error_low <= PWDATA[POS_EXT_ERROR_LOW];
            local_channel <= PWDATA[POS_FORCE_LOCAL_CHANNEL+1:POS_FORCE_LOCAL_CHANNEL];
         end
      end
   end

   generate
      for (g = 0; g < NUM_GROUPS; g++)
      begin : g_mem
         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               members[g] <= (g == 0) ? RST_GROUP_ONE_MEMBERS[NUM_WARN-1:0] :
                             RST_OTHER_GROUP_MEMBERS[NUM_WARN-1:0]; // see R3
            else if (CE && wr && PADDR == OFF_GROUP_BASE + 8'(4 * g))
               members[g] <= PWDATA[NUM_WARN-1:0];
         end
      end
   endgenerate

   // Error latches. A new error in the clearing cycle keeps the latch set.
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         error_latched <= 1'b0;
         overload_latched <= 1'b0;
      end
      else if (CE)
      begin
         if (ERROR_EVENT)
            error_latched <= 1'b1;
         else if (rise[FN_FAULT_CLEAR] && !ERROR_CAUSE) // see R7, R23
            error_latched <= 1'b0;
         if (OVERLOAD_EVENT)
            overload_latched <= 1'b1;
         else if (rise[FN_THERMAL_CLEAR] && !OVERLOAD_CAUSE) // see R14, R24
            overload_latched <= 1'b0;
      end
   end

   always_comb
   begin
      cond_value = 1'b0;
      unique case (out_cond)
         COND_FAULT_STATE: cond_value = FAULT_STATE;
         COND_RUNNING: cond_value = RUNNING;
         COND_READY: cond_value = READY;
         COND_DISPLAY_CONTROL: cond_value = DISPLAY_CONTROL; // see R22
         COND_LINE_CONTACTOR: cond_value = LINE_CONTACTOR && !act[FN_DEVICE_LOCKOUT];
         COND_INHIBITED_ERRORS: cond_value = act[FN_ERROR_INHIBIT]; // see R21
         COND_SECOND_PARAMETERS: cond_value = act[FN_ALTERNATE_PARAMETER];
         COND_MOTOR_OVERLOAD_WARNING: cond_value = WARN_IN[MOTOR_OVERLOAD_WARN_IDX];
         default:
            if (out_cond >= COND_GROUP_ONE && out_cond < COND_INHIBITED_ERRORS)
               cond_value = group_hit[3'(out_cond - COND_GROUP_ONE)]; // see R1, R19
      endcase
   end

   // All function outputs are registered, so they lag the synced pin by one edge.
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         WARN_VISIBLE <= '0;
         GROUP_ACTIVE <= '0;
         ERROR_LATCHED <= 1'b0;
         ERROR_RECORD <= 1'b0;
         FAULT_TRIP <= 1'b0;
         OVERLOAD_LATCHED <= 1'b0;
         USER_ERROR <= 1'b0;
         CHANNEL_TWO <= 1'b0;
         FORCE_LOCAL <= 1'b0;
         FORCE_LOCAL_CHANNEL <= RST_FORCE_LOCAL_CHANNEL;
         CONTACTOR_FORCE_OPEN <= 1'b0;
         STOP_COAST <= 1'b0;
         STOP_NORMAL <= 1'b0;
         BYPASS_OPEN <= 1'b0;
         SECOND_PARAM_SET <= 1'b0;
         PREHEAT_START <= 1'b0;
         DOUT_ONE <= 1'b0;
      end
      else if (CE)
      begin
         WARN_VISIBLE <= WARN_IN & any_member; // see R2
         GROUP_ACTIVE <= group_hit; // see R1
         ERROR_LATCHED <= error_latched;
         ERROR_RECORD <= ERROR_EVENT; // see R11
         FAULT_TRIP <= error_latched && !act[FN_ERROR_INHIBIT]; // see R11
         OVERLOAD_LATCHED <= overload_latched;
         USER_ERROR <= act[FN_USER_ERROR]; // see R8
         CHANNEL_TWO <= act[FN_CHANNEL_SWITCH]; // see R9
         FORCE_LOCAL <= act[FN_FORCE_LOCAL]; // see R10
         FORCE_LOCAL_CHANNEL <= local_channel; // see R10
         CONTACTOR_FORCE_OPEN <= act[FN_DEVICE_LOCKOUT]; // see R12
         STOP_COAST <= STOP_REQUEST && act[FN_COAST_STOP]; // see R13
         STOP_NORMAL <= STOP_REQUEST && !act[FN_COAST_STOP]; // see R13
         BYPASS_OPEN <= act[FN_CASCADE_HANDOVER]; // see R15
         SECOND_PARAM_SET <= act[FN_ALTERNATE_PARAMETER]; // see R16
         PREHEAT_START <= rise[FN_PREHEAT]; // see R17
         DOUT_ONE <= cond_value ^ out_negative; // see R20
      end
   end

endmodule : io_function_assignment

// ==== field_wiring.sv ====
`timescale 1ns/1ps

module field_wiring
(
   input wire logic clk,
   input wire logic lvl_a,
   input wire logic lvl_b,
   output logic din_a,
   output logic din_b
);
   // Contacts switch after a clock edge; each pin simply follows its level.
   always_ff @(posedge clk)
   begin
      din_a <= lvl_a;
      din_b <= lvl_b;
   end
endmodule : field_wiring

// ==== io_function_assignment_assertions.sv ====
`timescale 1ns/1ps

module io_function_assignment_checker
#(
   parameter int NUM_WARN = 16
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [NUM_WARN-1:0] WARN_IN,
   input wire logic [NUM_WARN-1:0] WARN_VISIBLE,
   input wire logic [io_route_pkg::NUM_GROUPS-1:0] GROUP_ACTIVE,
   input wire logic ERROR_EVENT,
   input wire logic ERROR_RECORD,
   input wire logic ERROR_LATCHED,
   input wire logic OVERLOAD_EVENT,
   input wire logic OVERLOAD_LATCHED,
   input wire logic STOP_REQUEST,
   input wire logic STOP_COAST,
   input wire logic STOP_NORMAL,
   input wire logic PREHEAT_START
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   sequence s_err_latched;
      ##2 ERROR_LATCHED;
   endsequence
   sequence s_ovl_latched;
      ##2 OVERLOAD_LATCHED;
   endsequence

   property p_visible_subset;
      !(|(WARN_VISIBLE & ~$past(WARN_IN)));
   endproperty
   property p_group_cause;
      |GROUP_ACTIVE |-> |$past(WARN_IN);
   endproperty
   property p_stop_excl;
      !(STOP_COAST && STOP_NORMAL);
   endproperty
   property p_stop_follow;
      STOP_REQUEST |=> (STOP_COAST || STOP_NORMAL);
   endproperty
   property p_stop_cause;
      (STOP_COAST || STOP_NORMAL) |-> $past(STOP_REQUEST);
   endproperty
   property p_record;
      ERROR_RECORD == $past(ERROR_EVENT);
   endproperty
   property p_err_set;
      ERROR_EVENT |-> s_err_latched;
   endproperty
   property p_err_rise;
      $rose(ERROR_LATCHED) |-> $past(ERROR_EVENT, 2);
   endproperty
   property p_ovl_set;
      OVERLOAD_EVENT |-> s_ovl_latched;
   endproperty
   property p_preheat_pulse;
      PREHEAT_START |=> !PREHEAT_START;
   endproperty

   a_visible_subset: assert property (p_visible_subset)
      else $error("visible warning not raised");
   a_group_cause: assert property (p_group_cause)
      else $error("group active without warning");
   a_stop_excl: assert property (p_stop_excl)
      else $error("both stop kinds at once");
   a_stop_follow: assert property (p_stop_follow)
      else $error("stop request not executed");
   a_stop_cause: assert property (p_stop_cause)
      else $error("stop without request");
   a_record: assert property (p_record)
      else $error("error record mismatch");
   a_err_set: assert property (p_err_set)
      else $error("error not latched");
   a_err_rise: assert property (p_err_rise)
      else $error("error latch without event");
   a_ovl_set: assert property (p_ovl_set)
      else $error("overload not latched");
   a_preheat_pulse: assert property (p_preheat_pulse)
      else $error("preheat start too long");
endmodule : io_function_assignment_checker

bind io_function_assignment io_function_assignment_checker #(.NUM_WARN(NUM_WARN)) u_chk (
   .CLK(CLK), .RSTN(RSTN), .WARN_IN(WARN_IN), .WARN_VISIBLE(WARN_VISIBLE),
   .GROUP_ACTIVE(GROUP_ACTIVE), .ERROR_EVENT(ERROR_EVENT), .ERROR_RECORD(ERROR_RECORD),
   .ERROR_LATCHED(ERROR_LATCHED), .OVERLOAD_EVENT(OVERLOAD_EVENT),
   .OVERLOAD_LATCHED(OVERLOAD_LATCHED), .STOP_REQUEST(STOP_REQUEST),
   .STOP_COAST(STOP_COAST), .STOP_NORMAL(STOP_NORMAL), .PREHEAT_START(PREHEAT_START));

// ==== io_function_assignment_tb.sv ====
`timescale 1ns/1ps

module io_function_assignment_tb;
   import io_route_pkg::*;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR, err;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic lvl_a = 1'b0, lvl_b = 1'b0, DIN_A, DIN_B, seen_pre = 1'b0;
   logic [15:0] WARN_IN = 16'h0, WARN_VISIBLE;
   logic [4:0] cnd = 5'h00, GROUP_ACTIVE;
   logic [2:0] ev = 3'h0;
   logic ERROR_CAUSE = 1'b1, OVERLOAD_CAUSE = 1'b1;
   logic ERROR_LATCHED, ERROR_RECORD, FAULT_TRIP, OVERLOAD_LATCHED, USER_ERROR;
   logic CHANNEL_TWO, FORCE_LOCAL, CONTACTOR_FORCE_OPEN, STOP_COAST, STOP_NORMAL;
   logic BYPASS_OPEN, SECOND_PARAM_SET, PREHEAT_START, DOUT_ONE;
   logic [1:0] FORCE_LOCAL_CHANNEL;
   int n_mismatch = 0;
   int n_compared = 0;

   always #50 CLK = ~CLK;

   field_wiring field (.clk(CLK), .lvl_a(lvl_a), .lvl_b(lvl_b), .din_a(DIN_A), .din_b(DIN_B));

   io_function_assignment #(.NUM_WARN(16)) dut (
      .CLK(CLK), .RSTN(RSTN), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .DIN_A(DIN_A), .DIN_B(DIN_B), .WARN_IN(WARN_IN), .FAULT_STATE(cnd[0]),
      .RUNNING(cnd[1]), .READY(cnd[2]), .DISPLAY_CONTROL(cnd[3]), .LINE_CONTACTOR(cnd[4]),
      .ERROR_EVENT(ev[0]), .ERROR_CAUSE(ERROR_CAUSE), .OVERLOAD_EVENT(ev[1]),
      .OVERLOAD_CAUSE(OVERLOAD_CAUSE), .STOP_REQUEST(ev[2]), .WARN_VISIBLE(WARN_VISIBLE),
      .GROUP_ACTIVE(GROUP_ACTIVE), .ERROR_LATCHED(ERROR_LATCHED), .ERROR_RECORD(ERROR_RECORD),
      .FAULT_TRIP(FAULT_TRIP), .OVERLOAD_LATCHED(OVERLOAD_LATCHED), .USER_ERROR(USER_ERROR),
      .CHANNEL_TWO(CHANNEL_TWO), .FORCE_LOCAL(FORCE_LOCAL),
      .FORCE_LOCAL_CHANNEL(FORCE_LOCAL_CHANNEL), .CONTACTOR_FORCE_OPEN(CONTACTOR_FORCE_OPEN),
      .STOP_COAST(STOP_COAST), .STOP_NORMAL(STOP_NORMAL), .BYPASS_OPEN(BYPASS_OPEN),
      .SECOND_PARAM_SET(SECOND_PARAM_SET), .PREHEAT_START(PREHEAT_START), .DOUT_ONE(DOUT_ONE));

   // A start pulse lasts one cycle; a sticky flag keeps it.
   always @(posedge CLK)
      if (PREHEAT_START === 1'b1)
         seen_pre <= 1'b1;

   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1)
         @(posedge CLK);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk

   // Five edges cover the field flop, both synchronisers and the output.
   task settle;
      repeat (5) @(posedge CLK);
      @(negedge CLK);
   endtask : settle

   task pins(input logic a, input logic b);
      @(posedge CLK);
      lvl_a <= a;
      lvl_b <= b;
      settle;
   endtask : pins

   task pulse(input int i);
      @(posedge CLK) ev[i] <= 1'b1;
      @(posedge CLK) ev[i] <= 1'b0;
      @(negedge CLK);
   endtask : pulse

   task done(input string s);
      $display("test %s done", s);
   endtask : done

   initial
   begin
      repeat (20000) @(posedge CLK);
      n_mismatch++;
      finish_test;
   end

   initial
   begin
      repeat (5) @(posedge CLK);
      RSTN <= 1'b1;
      repeat (3) @(posedge CLK);
      rdchk(OFF_INPUT_A_SELECT, 32'h7);
      rdchk(OFF_INPUT_B_SELECT, 32'h4);
      rdchk(OFF_OUTPUT_ONE_CONFIG, 32'hd);
      rdchk(OFF_GROUP_BASE, 32'h7);
      rdchk(8'h2c, 32'h0);
      chk(32'(err), 32'h1);
      done("defaults");
      @(posedge CLK) WARN_IN <= 16'h0028;
      settle;
      chk({WARN_VISIBLE, GROUP_ACTIVE, DOUT_ONE}, 22'h1);
      @(posedge CLK) WARN_IN <= 16'h0024;
      settle;
      chk({WARN_VISIBLE, GROUP_ACTIVE, DOUT_ONE}, {16'h0004, 5'h01, 1'b0});
      wr(OFF_GROUP_BASE + 8'h10, 32'h20);
      settle;
      chk({WARN_VISIBLE, GROUP_ACTIVE}, {16'h0024, 5'h11});
      for (int g = 0; g < 5; g++)
      begin
         wr(OFF_OUTPUT_ONE_CONFIG, 32'(COND_GROUP_ONE) + 32'(g));
         settle;
         chk(DOUT_ONE, (g == 0 || g == 4));
      end
      wr(OFF_OUTPUT_ONE_CONFIG, 32'h100 | 32'(COND_GROUP_ONE));
      settle;
      chk(DOUT_ONE, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         wr(OFF_OUTPUT_ONE_CONFIG, 32'(i + 1));
         @(posedge CLK) cnd <= 5'h01 << i;
         settle;
         chk(DOUT_ONE, 1'b1);
         @(posedge CLK) cnd <= ~(5'h01 << i);
         settle;
         chk(DOUT_ONE, 1'b0);
      end
      done("outputs");
      pins(1'b1, 1'b1);
      pulse(2);
      chk({STOP_COAST, STOP_NORMAL, FORCE_LOCAL}, 3'b101);
      pins(1'b0, 1'b0);
      pulse(2);
      chk({STOP_COAST, STOP_NORMAL, FORCE_LOCAL}, 3'b010);
      wr(OFF_INPUT_A_SELECT, 32'(FN_DEVICE_LOCKOUT));
      settle;
      chk(CONTACTOR_FORCE_OPEN, 1'b1);
      pins(1'b0, 1'b0);
      wr(OFF_INPUT_A_SELECT, 32'(FN_ALTERNATE_PARAMETER));
      settle;
      chk({CONTACTOR_FORCE_OPEN, SECOND_PARAM_SET}, 2'b00);
      pins(1'b1, 1'b0);
      chk(SECOND_PARAM_SET, 1'b1);
      wr(OFF_OUTPUT_ONE_CONFIG, 32'(COND_SECOND_PARAMETERS));
      settle;
      chk(DOUT_ONE, 1'b1);
      rdchk(OFF_SOURCE_ASSIGN, (32'(SRC_INPUT_A) << 20) | (32'(SRC_INPUT_B) << 8));
      wr(OFF_INPUT_A_SELECT, 32'(FN_CHANNEL_SWITCH));
      rdchk(OFF_INPUT_A_SELECT, 32'(FN_ALTERNATE_PARAMETER));
      wr(OFF_SOURCE_ASSIGN, 32'h23);
      wr(OFF_INPUT_B_SELECT, 32'(FN_PREHEAT));
      rdchk(OFF_INPUT_B_SELECT, 32'(FN_CHANNEL_SWITCH));
      settle;
      chk(CHANNEL_TWO, 1'b0);
      pins(1'b1, 1'b1);
      chk(CHANNEL_TWO, 1'b1);
      wr(OFF_SOURCE_ASSIGN, 32'h03);
      done("assignment");
      wr(OFF_INPUT_A_SELECT, 32'(FN_USER_ERROR));
      settle;
      chk(USER_ERROR, 1'b1);
      wr(OFF_OPTIONS, 32'h5);
      settle;
      chk({USER_ERROR, FORCE_LOCAL_CHANNEL}, 3'b010);
      pins(1'b0, 1'b0);
      chk(USER_ERROR, 1'b1);
      wr(OFF_INPUT_A_SELECT, 32'(FN_FORCE_LOCAL));
      pins(1'b1, 1'b0);
      chk(FORCE_LOCAL, 1'b1);
      wr(OFF_INPUT_A_SELECT, 32'(FN_ERROR_INHIBIT));
      wr(OFF_OUTPUT_ONE_CONFIG, 32'(COND_INHIBITED_ERRORS));
      settle;
      chk(DOUT_ONE, 1'b1);
      pulse(0);
      chk(ERROR_RECORD, 1'b1);
      settle;
      chk({ERROR_LATCHED, FAULT_TRIP}, 2'b10);
      wr(OFF_INPUT_A_SELECT, 32'(FN_FAULT_CLEAR));
      settle;
      chk({ERROR_LATCHED, FAULT_TRIP, DOUT_ONE}, 3'b110);
      pins(1'b0, 1'b0);
      @(posedge CLK) ERROR_CAUSE <= 1'b0;
      pins(1'b1, 1'b0);
      chk(ERROR_LATCHED, 1'b0);
      pulse(0);
      settle;
      chk(ERROR_LATCHED, 1'b1);
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b0);
      chk(ERROR_LATCHED, 1'b0);
      done("errors");
      wr(OFF_INPUT_A_SELECT, 32'(FN_THERMAL_CLEAR));
      pins(1'b0, 1'b0);
      pulse(1);
      pins(1'b1, 1'b0);
      chk(OVERLOAD_LATCHED, 1'b1);
      pins(1'b0, 1'b0);
      @(posedge CLK) OVERLOAD_CAUSE <= 1'b0;
      pins(1'b1, 1'b0);
      chk(OVERLOAD_LATCHED, 1'b0);
      wr(OFF_INPUT_A_SELECT, 32'(FN_CASCADE_HANDOVER));
      settle;
      chk(BYPASS_OPEN, 1'b1);
      pins(1'b0, 1'b0);
      chk({BYPASS_OPEN, seen_pre}, 2'b00);
      wr(OFF_INPUT_A_SELECT, 32'(FN_PREHEAT));
      pins(1'b1, 1'b0);
      chk(seen_pre, 1'b1);
      done("functions");
      finish_test;
   end
endmodule : io_function_assignment_tb
